/* hw/disk_tf_pkg.sv */
// Summary of operation
// - low byte: bits 0-7, previous 24-31
// - mid byte: bits 8-15, previous 32-39
// - high byte: bits 16-23, previous 40-47
// - zero count means 256 or 65536
// - count reads remaining sectors at completion
// - status bit order, corrected/index read zero
// - status updated on error and completion
// - status read acknowledges pending interrupt
// - busy: any read returns status
// - ready low until device accepts commands
// - fault set on write fault, read clears
// - seek flag drops, rises, freezes after error
// - seek flag set in standby or sleep
// - error set on failure, cleared next command
// - soft reset is control bit set then cleared
// - abort host, flush cache, POR-only diagnostics
// - standby timer reset by POR, link reset
// - reset in sleep goes to standby
// - soft reset reverts parameters if enabled
// - reset loads default task file values
// - diagnostic codes 01h to 05h
package disk_tf_pkg;

	// Register select codes on the shadow register port
	localparam logic [3:0] REG_FEAT_ERR  = 4'h1;
	localparam logic [3:0] REG_COUNT     = 4'h2;
	localparam logic [3:0] REG_LOW       = 4'h3;
	localparam logic [3:0] REG_MID       = 4'h4;
	localparam logic [3:0] REG_HIGH      = 4'h5;
	localparam logic [3:0] REG_DEVICE    = 4'h6;
	localparam logic [3:0] REG_CMD_STAT  = 4'h7;
	localparam logic [3:0] REG_CTRL_ALT  = 4'h8;

	// Reset values
	localparam logic [7:0] RST_COUNT     = 8'h01;
	localparam logic [7:0] RST_LOW       = 8'h01;
	localparam logic [7:0] RST_MID       = 8'h00;
	localparam logic [7:0] RST_HIGH      = 8'h00;
	localparam logic [7:0] RST_DEVICE    = 8'h00;
	localparam logic [7:0] RST_STATUS    = 8'h50;
	localparam logic [7:0] RST_CTRL      = 8'h08;
	localparam logic [7:0] RST_TIMER     = 8'h00;

	// Diagnostic codes
	localparam logic [7:0] DIAG_OK       = 8'h01;
	localparam logic [7:0] DIAG_FORMAT   = 8'h02;
	localparam logic [7:0] DIAG_BUFFER   = 8'h03;
	localparam logic [7:0] DIAG_ECC      = 8'h04;
	localparam logic [7:0] DIAG_CPU      = 8'h05;

	// Set-features subcommands and opcode
	localparam logic [7:0] FEAT_REVERT_ON  = 8'hcc;
	localparam logic [7:0] FEAT_REVERT_OFF = 8'h66;
	localparam logic [7:0] CMD_SET_FEATURES = 8'hef;

	// Status bit positions
	localparam int unsigned ST_BUSY  = 7;
	localparam int unsigned ST_READY = 6;
	localparam int unsigned ST_FAULT = 5;
	localparam int unsigned ST_SEEK  = 4;
	localparam int unsigned ST_DREQ  = 3;
	localparam int unsigned ST_CORRECTED_DATA_FLAG  = 2;
	localparam int unsigned ST_INDEX = 1;
	localparam int unsigned ST_ERROR = 0;

	// Device control bit positions
	localparam int unsigned CTL_HOB  = 7;
	localparam int unsigned CTL_SOFT_RESET_BIT = 2;
	localparam int unsigned CTL_NIEN = 1;

	// Zero-count meanings, 28-bit and 48-bit
	localparam logic [16:0] ZERO_CNT_28 = 17'h00100;
	localparam logic [16:0] ZERO_CNT_48 = 17'h10000;

	typedef enum logic [3:0] {
		PM_ACTIVE  = 4'b0001,
		PM_IDLE    = 4'b0010,
		PM_STANDBY = 4'b0100,
		PM_SLEEP   = 4'b1000
	} pwr_mode_e;

	typedef enum logic [2:0] {
		RS_IDLE  = 3'b001,
		RS_FLUSH = 3'b010,
		RS_INIT  = 3'b100
	} rst_state_e;

	typedef struct packed {
		logic [3:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} host_acc_s;

	typedef struct packed {
		logic        done;
		logic        err;
		logic        ext48;
		logic [47:0] logical_block_address;
		logic [15:0] remain;
		logic [7:0]  error_bits;
	} cmd_result_s;

endpackage : disk_tf_pkg

/* hw/task_byte_pair.sv */
// Current and previous byte of one task-file register
module task_byte_pair #(
	parameter logic [7:0] INIT = 8'h00
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       init_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       load_i,
	input  wire logic       load_prev_i,
	input  wire logic [7:0] cur_i,
	input  wire logic [7:0] prev_i,
	output logic [7:0]      cur_o,
	output logic [7:0]      prev_o
);
	logic [7:0] cur_d, cur_q;
	logic [7:0] prev_d, prev_q;

	// Host writes push the old byte down; completion reloads the current byte, and the previous one only when load_prev_i is set
	always_comb begin
		cur_d  = cur_q;
		prev_d = prev_q;
		if (init_i) begin
			cur_d  = INIT;
			prev_d = INIT;
		end else if (load_i) begin
			cur_d = cur_i;
			if (load_prev_i) begin
				prev_d = prev_i;
			end
		end else if (wr_i) begin
			prev_d = cur_q;
			cur_d  = wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cur_q  <= INIT;
			prev_q <= INIT;
		end else begin
			cur_q  <= cur_d;
			prev_q <= prev_d;
		end
	end

	assign cur_o  = cur_q;
	assign prev_o = prev_q;
endmodule : task_byte_pair

/* hw/reset_sequencer.sv */
// Link and software reset sequencing
module reset_sequencer
	import disk_tf_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic link_rst_i,
	input  wire logic soft_rst_i,
	input  wire logic cache_clean_i,
	output logic      abort_host_o,
	output logic      abort_dev_o,
	output logic      init_o,
	output logic      soft_o,
	output logic      active_o
);
	rst_state_e st_d, st_q;
	logic       ah_d, ah_q, ad_d, ad_q, in_d, in_q, sf_d, sf_q;

	// Host side aborts at once; internal work waits for the cache
	always_comb begin
		st_d = st_q;
		ah_d = 1'b0;
		ad_d = 1'b0;
		in_d = 1'b0;
		sf_d = sf_q;
		case (st_q)
			RS_IDLE: begin
				if (link_rst_i || soft_rst_i) begin
					st_d = RS_FLUSH;
					ah_d = 1'b1;
					sf_d = soft_rst_i && !link_rst_i;
				end
			end
			RS_FLUSH: begin
				if (cache_clean_i) begin
					st_d = RS_INIT;
					ad_d = 1'b1;
				end
			end
			RS_INIT: begin
				st_d = RS_IDLE;
				in_d = 1'b1;
			end
			default: st_d = RS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= RS_IDLE;
			ah_q <= 1'b0;
			ad_q <= 1'b0;
			in_q <= 1'b0;
			sf_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ah_q <= ah_d;
			ad_q <= ad_d;
			in_q <= in_d;
			sf_q <= sf_d;
		end
	end

	assign abort_host_o = ah_q;
	assign abort_dev_o  = ad_q;
	assign init_o       = in_q;
	assign soft_o       = sf_q;
	assign active_o     = (st_q != RS_IDLE);
endmodule : reset_sequencer

/* hw/disk_task_file.sv */
// Device-side command-block registers, status and reset handling
module disk_task_file
	import disk_tf_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  disk_tf_pkg::host_acc_s host_i,
	output logic [7:0]             rdata_o,
	output logic                   intrq_o,
	output logic                   busy_o,
	input  wire logic              link_rst_i,
	output logic                   cmd_valid_o,
	output logic [7:0]             cmd_code_o,
	output logic [47:0]            lba_o,
	output logic [16:0]            xfer_count_o,
	input  disk_tf_pkg::cmd_result_s result_i,
	input  wire logic              ready_i,
	input  wire logic              data_req_i,
	input  wire logic              write_fault_i,
	input  wire logic              seek_start_i,
	input  wire logic              seek_settled_i,
	input  wire logic              pwr_set_i,
	input  disk_tf_pkg::pwr_mode_e pwr_mode_i,
	output disk_tf_pkg::pwr_mode_e pwr_mode_o,
	input  wire logic              diag_done_i,
	input  wire logic [7:0]        diag_code_i,
	output logic                   diag_run_o,
	input  wire logic              cache_clean_i,
	output logic                   abort_host_o,
	output logic                   abort_dev_o,
	output logic                   revert_o,
	input  wire logic              timer_load_i,
	input  wire logic [7:0]        timer_value_i,
	output logic [7:0]             standby_timer_o
);
	import disk_tf_pkg::*;

	// Transfer length of a count value, zero meaning the maximum
	function automatic logic [16:0] xfer_len(input logic [15:0] cnt,
	                                         input logic        ext48);
		logic [16:0] len;
		len = {1'b0, cnt};
		if (ext48 && cnt == 16'h0000) begin
			len = ZERO_CNT_48;
		end else if (!ext48 && cnt[7:0] == 8'h00) begin
			len = ZERO_CNT_28;
		end else if (!ext48) begin
			len = {9'h000, cnt[7:0]};
		end
		return len;
	endfunction : xfer_len

	logic        busy_d, busy_q;
	logic        ready_d, ready_q;
	logic        fault_d, fault_q;
	logic        seek_d, seek_q;
	logic        settled_d, settled_q;
	logic        frozen_d, frozen_q;
	logic        err_d, err_q;
	logic        irq_d, irq_q;
	logic [7:0]  ctrl_d, ctrl_q;
	logic [7:0]  dev_d, dev_q;
	logic [7:0]  feat_d, feat_q;
	logic [7:0]  error_d, error_q;
	logic [7:0]  diag_d, diag_q;
	logic [7:0]  cmd_d, cmd_q;
	logic        cmdv_d, cmdv_q;
	logic        rev_en_d, rev_en_q;
	logic        rev_d, rev_q;
	logic        por_d, por_q;
	logic        drun_d, drun_q;
	logic [7:0]  timer_d, timer_q;
	logic [7:0]  rdata_d, rdata_q;
	pwr_mode_e   pm_d, pm_q;
	logic [7:0]  status;
	logic        stat_rd, cmd_wr, soft_reset_bit_fall, soft_reset_bit_rise;
	logic        seq_init, seq_soft, seq_active;
	logic        error_event, task_init;
	logic [3:0]  pair_wr;
	logic [7:0]  pair_cur [4];
	logic [7:0]  pair_prev [4];
	logic [7:0]  load_cur [4];
	logic [7:0]  load_prev [4];

	// Status byte; corrected and index are tied low
	assign status = {busy_q, ready_q, fault_q, seek_q,
	                 data_req_i, 1'b0, 1'b0, err_q};

	// Host strobes; writes are dropped while busy, except device control
	assign stat_rd   = host_i.rd && host_i.addr == REG_CMD_STAT;
	assign cmd_wr    = host_i.wr && !busy_q &&
	                   host_i.addr == REG_CMD_STAT;
	assign soft_reset_bit_rise = host_i.wr && host_i.addr == REG_CTRL_ALT &&
	                   host_i.wdata[CTL_SOFT_RESET_BIT] && !ctrl_q[CTL_SOFT_RESET_BIT];
	assign soft_reset_bit_fall = host_i.wr && host_i.addr == REG_CTRL_ALT &&
	                   !host_i.wdata[CTL_SOFT_RESET_BIT] &&
	                   ctrl_q[CTL_SOFT_RESET_BIT];
	assign error_event = write_fault_i || (result_i.done && result_i.err);
	assign task_init   = seq_init;

	reset_sequencer u_seq (
		.clk_i         (clk_i),
		.nrst_i        (nrst_i),
		.link_rst_i    (link_rst_i),
		.soft_rst_i    (soft_reset_bit_fall),
		.cache_clean_i (cache_clean_i),
		.abort_host_o  (abort_host_o),
		.abort_dev_o   (abort_dev_o),
		.init_o        (seq_init),
		.soft_o        (seq_soft),
		.active_o      (seq_active)
	);

	// Completion values for the four byte pairs
	always_comb begin
		load_cur[0]  = result_i.remain[7:0];
		load_prev[0] = result_i.remain[15:8];
		load_cur[1]  = result_i.logical_block_address[7:0];
		load_prev[1] = result_i.logical_block_address[31:24];
		load_cur[2]  = result_i.logical_block_address[15:8];
		load_prev[2] = result_i.logical_block_address[39:32];
		load_cur[3]  = result_i.logical_block_address[23:16];
		load_prev[3] = result_i.logical_block_address[47:40];
	end

	// One write strobe per pair, in register select order
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pair_wr[i] = host_i.wr && !busy_q &&
			             host_i.addr == REG_COUNT + 4'(i);
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_pair
		task_byte_pair #(
			.INIT ((g == 0) ? RST_COUNT : (g == 1) ? RST_LOW :
			       (g == 2) ? RST_MID : RST_HIGH)
		) u_pair (
			.clk_i       (clk_i),
			.nrst_i      (nrst_i),
			.init_i      (task_init),
			.wr_i        (pair_wr[g]),
			.wdata_i     (host_i.wdata),
			.load_i      (result_i.done),
			.load_prev_i (result_i.ext48),
			.cur_i       (load_cur[g]),
			.prev_i      (load_prev[g]),
			.cur_o       (pair_cur[g]),
			.prev_o      (pair_prev[g])
		);
	end

	// Status flags
	always_comb begin
		busy_d   = busy_q;
		ready_d  = ready_i;
		fault_d  = fault_q;
		seek_d   = seek_q;
		settled_d = settled_q;
		frozen_d = frozen_q;
		err_d    = err_q;
		irq_d    = irq_q;
		if (cmd_wr || soft_reset_bit_rise || link_rst_i) begin
			busy_d = 1'b1;
		end else if (result_i.done || (seq_init && !ctrl_q[CTL_SOFT_RESET_BIT])) begin
			busy_d = 1'b0;
		end else if (!seq_active && !ctrl_q[CTL_SOFT_RESET_BIT] && !por_q &&
		             busy_q && !cmdv_q && soft_reset_bit_fall) begin
			busy_d = 1'b1;
		end
		if (stat_rd) begin
			fault_d  = 1'b0;
			frozen_d = 1'b0;
			irq_d    = 1'b0;
		end
		// A fault or error arriving with the read still wins
		if (write_fault_i) begin
			fault_d = 1'b1;
		end
		if (error_event) begin
			frozen_d = 1'b1;
		end
		// Head state is tracked while frozen so the flag catches up later
		if (seek_start_i) begin
			settled_d = 1'b0;
		end else if (seek_settled_i) begin
			settled_d = 1'b1;
		end
		if (pm_q == PM_STANDBY || pm_q == PM_SLEEP) begin
			seek_d = 1'b1;
		end else if (!frozen_q) begin
			seek_d = settled_d;
		end
		if (cmd_wr) begin
			err_d = 1'b0;
		end else if (result_i.done) begin
			err_d = result_i.err;
		end
		if (result_i.done && !ctrl_q[CTL_NIEN]) begin
			irq_d = 1'b1;
		end
		if (task_init) begin
			fault_d  = 1'b0;
			seek_d   = RST_STATUS[ST_SEEK];
			err_d    = RST_STATUS[ST_ERROR];
			frozen_d = 1'b0;
			irq_d    = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_q   <= 1'b0;
			ready_q  <= 1'b0;
			fault_q  <= 1'b0;
			seek_q   <= RST_STATUS[ST_SEEK];
			settled_q <= RST_STATUS[ST_SEEK];
			frozen_q <= 1'b0;
			err_q    <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			busy_q   <= busy_d;
			ready_q  <= ready_d;
			fault_q  <= fault_d;
			seek_q   <= seek_d;
			settled_q <= settled_d;
			frozen_q <= frozen_d;
			err_q    <= err_d;
			irq_q    <= irq_d;
		end
	end

	// Control, device, feature, error and command registers
	always_comb begin
		ctrl_d   = ctrl_q;
		dev_d    = dev_q;
		feat_d   = feat_q;
		error_d  = error_q;
		diag_d   = diag_q;
		cmd_d    = cmd_q;
		cmdv_d   = cmd_wr;
		rev_en_d = rev_en_q;
		rev_d    = 1'b0;
		if (host_i.wr && host_i.addr == REG_CTRL_ALT) begin
			ctrl_d = host_i.wdata;
		end
		if (host_i.wr && !busy_q && host_i.addr == REG_DEVICE) begin
			dev_d = host_i.wdata;
		end
		if (host_i.wr && !busy_q && host_i.addr == REG_FEAT_ERR) begin
			feat_d = host_i.wdata;
		end
		if (cmd_wr) begin
			cmd_d = host_i.wdata;
			if (host_i.wdata == CMD_SET_FEATURES) begin
				if (feat_q == FEAT_REVERT_ON) begin
					rev_en_d = 1'b1;
				end else if (feat_q == FEAT_REVERT_OFF) begin
					rev_en_d = 1'b0;
				end
			end
		end
		if (diag_done_i) begin
			diag_d  = diag_code_i;
			error_d = diag_code_i;
		end
		if (result_i.done) begin
			error_d = result_i.error_bits;
			if (!result_i.ext48) begin
				dev_d[3:0] = result_i.logical_block_address[27:24];
			end
		end
		if (task_init) begin
			dev_d   = RST_DEVICE;
			error_d = diag_q;
			rev_d   = seq_soft && rev_en_q;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q   <= RST_CTRL;
			dev_q    <= RST_DEVICE;
			feat_q   <= 8'h00;
			error_q  <= DIAG_OK;
			diag_q   <= DIAG_OK;
			cmd_q    <= 8'h00;
			cmdv_q   <= 1'b0;
			rev_en_q <= 1'b0;
			rev_q    <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			dev_q    <= dev_d;
			feat_q   <= feat_d;
			error_q  <= error_d;
			diag_q   <= diag_d;
			cmd_q    <= cmd_d;
			cmdv_q   <= cmdv_d;
			rev_en_q <= rev_en_d;
			rev_q    <= rev_d;
		end
	end

	// Power mode, standby timer and power-on diagnostics
	always_comb begin
		pm_d    = pm_q;
		timer_d = timer_q;
		por_d   = 1'b0;
		drun_d  = por_q;
		if (pwr_set_i) begin
			pm_d = pwr_mode_i;
		end
		if (abort_host_o && pm_q == PM_SLEEP) begin
			pm_d = PM_STANDBY;
		end
		if (timer_load_i) begin
			timer_d = timer_value_i;
		end
		// Soft reset leaves the timer alone
		if (abort_host_o && !seq_soft) begin
			timer_d = RST_TIMER;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pm_q    <= PM_ACTIVE;
			timer_q <= RST_TIMER;
			por_q   <= 1'b1;
			drun_q  <= 1'b0;
		end else begin
			pm_q    <= pm_d;
			timer_q <= timer_d;
			por_q   <= por_d;
			drun_q  <= drun_d;
		end
	end

	// Read mux; a busy device answers every read with status
	always_comb begin
		rdata_d = rdata_q;
		if (host_i.rd) begin
			if (busy_q) begin
				rdata_d = status;
			end else begin
				case (host_i.addr)
					REG_FEAT_ERR: rdata_d = error_q;
					REG_COUNT: rdata_d = ctrl_q[CTL_HOB] ?
					           pair_prev[0] : pair_cur[0];
					REG_LOW: rdata_d = ctrl_q[CTL_HOB] ?
					         pair_prev[1] : pair_cur[1];
					REG_MID: rdata_d = ctrl_q[CTL_HOB] ?
					         pair_prev[2] : pair_cur[2];
					REG_HIGH: rdata_d = ctrl_q[CTL_HOB] ?
					          pair_prev[3] : pair_cur[3];
					REG_DEVICE: rdata_d = dev_q;
					REG_CMD_STAT, REG_CTRL_ALT: rdata_d = status;
					default: rdata_d = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o         = rdata_q;
	assign intrq_o         = irq_q;
	assign busy_o          = busy_q;
	assign cmd_valid_o     = cmdv_q;
	assign cmd_code_o      = cmd_q;
	assign lba_o           = {pair_prev[3], pair_prev[2], pair_prev[1],
	                          pair_cur[3], pair_cur[2], pair_cur[1]};
	assign xfer_count_o    = xfer_len({pair_prev[0], pair_cur[0]},
	                                  result_i.ext48);
	assign pwr_mode_o      = pm_q;
	assign diag_run_o      = drun_q;
	assign revert_o        = rev_q;
	assign standby_timer_o = timer_q;
endmodule : disk_task_file

/* sim/host_model.sv */
// Host adapter side: shadow register accesses toward the block
module host_model
	import disk_tf_pkg::*;
#(
	parameter int HOLD_CYC = 1250
) (
	input  wire logic              clk_i,
	input  wire logic              busy_i,
	input  wire logic              dreq_i,
	input  wire logic [7:0]        rdata_i,
	output disk_tf_pkg::host_acc_s host_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle port at time zero
	initial host_o = '0;

	// Wait while the block may not be touched; bounded so a stuck flag ends
	task automatic hold_off(input logic [3:0] a, input logic w);
		int k;
		k = 0;
		while (k < 4000 && ((busy_i !== 1'b0 && a != REG_CTRL_ALT)
			|| (dreq_i !== 1'b0 && w && a == REG_CMD_STAT))) begin
			@(negedge clk_i);
			k++;
		end
	endtask : hold_off

	// One-cycle write strobe; data is scrambled once released
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		hold_off(a, 1'b1);
		@(negedge clk_i);
		host_o = '{a, 1'b1, 1'b0, d};
		@(negedge clk_i);
		host_o.wr = 1'b0;
		host_o.wdata = ~d;
	endtask : wr

	// One-cycle read strobe; any skips the busy wait on purpose
	task automatic rd(input logic [3:0] a, input logic any,
		output logic [7:0] d);
		if (!any)
			hold_off(a, 1'b0);
		@(negedge clk_i);
		host_o = '{a, 1'b0, 1'b1, 8'h00};
		@(negedge clk_i);
		host_o.rd = 1'b0;
		@(negedge clk_i);
		d = rdata_i;
	endtask : rd

	// Reset bit held long enough for the device to notice it
	task automatic soft_reset(input logic [7:0] c);
		wr(REG_CTRL_ALT, c | 8'h04);
		repeat (HOLD_CYC) @(negedge clk_i);
		wr(REG_CTRL_ALT, c);
	endtask : soft_reset

endmodule : host_model

/* sim/disk_task_file_chk.sv */
// Port-level checks on the command-block registers
module disk_task_file_chk
	import disk_tf_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               nrst_i,
	input  disk_tf_pkg::host_acc_s  host_i,
	input  wire logic [7:0]         rdata_o,
	input  wire logic               intrq_o,
	input  wire logic               busy_o,
	input  wire logic               link_rst_i,
	input  wire logic               cmd_valid_o,
	input  wire logic [7:0]         cmd_code_o,
	input  disk_tf_pkg::cmd_result_s result_i,
	input  wire logic               cache_clean_i,
	input  wire logic               abort_dev_o,
	input  disk_tf_pkg::pwr_mode_e  pwr_mode_o,
	input  wire logic               diag_run_o
);
	logic       nien_q, nien_d;
	logic [1:0] since_q, since_d;
	logic       stat_rd;

	assign stat_rd = host_i.rd && host_i.addr == REG_CMD_STAT;

	// Mask mirror and edges since reset; control writes land even if busy
	always_comb begin
		nien_d = nien_q;
		if (host_i.wr && host_i.addr == REG_CTRL_ALT)
			nien_d = host_i.wdata[CTL_NIEN];
		since_d = (since_q == 2'h3) ? since_q : since_q + 2'h1;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nien_q  <= 1'b0;
			since_q <= 2'h0;
		end else begin
			nien_q  <= nien_d;
			since_q <= since_d;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	property p_cmd;
		host_i.wr && host_i.addr == REG_CMD_STAT && !busy_o |=> busy_o
			&& cmd_valid_o && cmd_code_o == $past(host_i.wdata);
	endproperty
	a_cmd: assert property (p_cmd)
		else $error("command write did not start busy command");
	property p_done;
		result_i.done && busy_o |=> !busy_o;
	endproperty
	a_done: assert property (p_done)
		else $error("busy not cleared at completion");
	property p_irq;
		result_i.done && busy_o |=> intrq_o == !nien_q;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt does not follow mask at completion");
	property p_ack;
		stat_rd && !busy_o && !result_i.done |=> !intrq_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("status read left interrupt pending");
	property p_hold;
		intrq_o && !busy_o && !link_rst_i && !stat_rd && !host_i.wr
			|=> intrq_o;
	endproperty
	a_hold: assert property (p_hold)
		else $error("interrupt dropped without acknowledge");
	property p_busy_rd;
		host_i.rd && busy_o |=> rdata_o[ST_BUSY];
	endproperty
	a_busy_rd: assert property (p_busy_rd)
		else $error("read while busy did not return status");
	property p_abort;
		abort_dev_o |-> $past(cache_clean_i);
	endproperty
	a_abort: assert property (p_abort)
		else $error("device abort before cache committed");
	property p_sleep;
		link_rst_i && pwr_mode_o == PM_SLEEP
			|-> ##[1:3] pwr_mode_o == PM_STANDBY;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep not left for standby on link reset");
	property p_diag;
		diag_run_o |-> since_q != 2'h3;
	endproperty
	a_diag: assert property (p_diag)
		else $error("diagnostics started outside power-on");

endmodule : disk_task_file_chk

bind disk_task_file disk_task_file_chk chk (.clk_i, .nrst_i, .host_i,
	.rdata_o, .intrq_o, .busy_o, .link_rst_i, .cmd_valid_o, .cmd_code_o,
	.result_i, .cache_clean_i, .abort_dev_o, .pwr_mode_o, .diag_run_o);

/* sim/disk_task_file_tb.sv */
// Self-checking bench for the command-block registers
module disk_task_file_tb;
	import disk_tf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, nrst, lrst, rdy, dreq, wf, sks, skd;
	logic        pset, dgo, clean, tload, irq, busy, abd, rev, ah;
	logic [7:0]  dcode, tval, rdata, tmr;
	logic [47:0] logical_block_address;
	logic [16:0] xcnt;
	int          err_total, compares, nab, nrev, nah;
	host_acc_s   hacc;
	cmd_result_s res;
	pwr_mode_e   pmode, pm;

	disk_task_file dut (.clk_i(clk), .nrst_i(nrst), .host_i(hacc),
		.rdata_o(rdata), .intrq_o(irq), .busy_o(busy), .link_rst_i(lrst),
		.cmd_valid_o(), .cmd_code_o(), .lba_o(logical_block_address), .xfer_count_o(xcnt),
		.result_i(res), .ready_i(rdy), .data_req_i(dreq),
		.write_fault_i(wf), .seek_start_i(sks), .seek_settled_i(skd),
		.pwr_set_i(pset), .pwr_mode_i(pmode), .pwr_mode_o(pm),
		.diag_done_i(dgo), .diag_code_i(dcode), .diag_run_o(),
		.cache_clean_i(clean), .abort_host_o(ah), .abort_dev_o(abd),
		.revert_o(rev), .timer_load_i(tload), .timer_value_i(tval),
		.standby_timer_o(tmr));

	host_model host (.clk_i(clk), .busy_i(busy), .dreq_i(dreq),
		.rdata_i(rdata), .host_o(hacc));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Pulse counters; one-cycle outputs are easy to miss by polling
	always @(posedge clk) begin
		if (abd === 1'b1)
			nab++;
		if (rev === 1'b1)
			nrev++;
		if (ah === 1'b1)
			nah++;
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, 1'b0, d);
		chk(d, e);
	endtask : rchk

	// Completion report from the media side
	task automatic finish(input logic e, input logic [15:0] rm,
		input logic [47:0] a, input logic x, input logic [7:0] eb);
		@(negedge clk);
		res = '{1'b1, e, x, a, rm, eb};
		@(negedge clk);
		res.done = 1'b0;
		@(negedge clk);
	endtask : finish

	task automatic wait_idle();
		int k;
		k = 0;
		repeat (4) @(negedge clk);
		while (busy !== 1'b0 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		chk(busy, 1'b0);
	endtask : wait_idle

	task automatic defaults(input logic [7:0] diag);
		rchk(REG_COUNT, RST_COUNT);
		rchk(REG_LOW, RST_LOW);
		rchk(REG_MID, RST_MID);
		rchk(REG_HIGH, RST_HIGH);
		rchk(REG_DEVICE, RST_DEVICE);
		rchk(REG_CTRL_ALT, RST_STATUS);
		rchk(REG_CMD_STAT, RST_STATUS);
		rchk(REG_FEAT_ERR, diag);
	endtask : defaults

	task automatic t_power_up();
		repeat (4) @(negedge clk);
		rchk(REG_CMD_STAT, 8'h10);
		pulse(dgo);
		rdy = 1'b1;
		repeat (2) @(negedge clk);
		defaults(DIAG_OK);
		$display("test power_up done");
	endtask : t_power_up

	// Second write pushes the first into the previous byte
	task automatic t_pairs();
		for (int i = 0; i < 3; i++) begin
			host.wr(REG_LOW + 4'(i), 8'ha0 + 8'(i));
			host.wr(REG_LOW + 4'(i), 8'hb0 + 8'(i));
		end
		@(negedge clk);
		chk(logical_block_address, 48'ha2a1a0_b2b1b0);
		host.wr(REG_CTRL_ALT, 8'h88);
		rchk(REG_MID, 8'ha1);
		host.wr(REG_CTRL_ALT, 8'h08);
		host.wr(REG_COUNT, 8'h00);
		host.wr(REG_COUNT, 8'h00);
		@(negedge clk);
		chk(xcnt, ZERO_CNT_28);
		res.ext48 = 1'b1;
		#1 chk(xcnt, ZERO_CNT_48);
		$display("test pairs done");
	endtask : t_pairs

	task automatic t_cmd();
		logic [7:0] d;
		host.wr(REG_CMD_STAT, 8'h25);
		host.rd(REG_LOW, 1'b1, d);
		chk(d[7], 1'b1);
		finish(1'b1, 16'h0203, 48'h665544332211, 1'b1, 8'h10);
		chk(irq, 1'b1);
		rchk(REG_COUNT, 8'h03);
		rchk(REG_LOW, 8'h11);
		host.wr(REG_CTRL_ALT, 8'h80);
		rchk(REG_HIGH, 8'h66);
		host.wr(REG_CTRL_ALT, 8'h0a);
		rchk(REG_CMD_STAT, 8'h51);
		chk(irq, 1'b0);
		host.wr(REG_CMD_STAT, 8'h25);
		finish(1'b0, 16'h0000, 48'h0, 1'b1, 8'h00);
		chk(irq, 1'b0);
		rchk(REG_COUNT, 8'h00);
		rchk(REG_CMD_STAT, 8'h50);
		host.wr(REG_CTRL_ALT, 8'h08);
		$display("test cmd done");
	endtask : t_cmd

	// Alternate status reads must not clear fault or the seek freeze
	task automatic t_status();
		dreq = 1'b1;
		rchk(REG_CMD_STAT, 8'h58);
		dreq = 1'b0;
		pulse(sks);
		rchk(REG_CTRL_ALT, 8'h40);
		pulse(skd);
		pulse(wf);
		pulse(sks);
		rchk(REG_CTRL_ALT, 8'h70);
		rchk(REG_CMD_STAT, 8'h70);
		rchk(REG_CMD_STAT, 8'h40);
		pulse(skd);
		rchk(REG_CMD_STAT, 8'h50);
		$display("test status done");
	endtask : t_status

	task automatic t_link();
		pmode = PM_SLEEP;
		pulse(pset);
		pulse(sks);
		rchk(REG_CMD_STAT, 8'h50);
		tval = 8'h33;
		pulse(tload);
		pulse(lrst);
		wait_idle();
		chk(pm, PM_STANDBY);
		chk(tmr, RST_TIMER);
		defaults(DIAG_OK);
		pulse(skd);
		$display("test link done");
	endtask : t_link

	// Cache held dirty to prove the device abort waits for it
	task automatic t_soft();
		pmode = PM_IDLE;
		pulse(pset);
		tval = 8'h44;
		pulse(tload);
		host.wr(REG_FEAT_ERR, FEAT_REVERT_ON);
		host.wr(REG_CMD_STAT, CMD_SET_FEATURES);
		finish(1'b0, 16'h0000, 48'h0, 1'b0, 8'h00);
		rchk(REG_CMD_STAT, 8'h50);
		dcode = DIAG_BUFFER;
		pulse(dgo);
		clean = 1'b0;
		nab = 0;
		nrev = 0;
		nah = 0;
		host.soft_reset(8'h08);
		repeat (10) @(negedge clk);
		chk(nab, 0);
		chk(nah, 1);
		clean = 1'b1;
		wait_idle();
		chk(nab, 1);
		chk(nrev, 1);
		chk(tmr, 8'h44);
		chk(pm, PM_IDLE);
		defaults(DIAG_BUFFER);
		$display("test soft done");
	endtask : t_soft

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Watchdog well past the soft reset hold and all waits
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		summarize();
	end

	// Reset for 10 cycles, then the scenarios in order
	initial begin
		{nrst, lrst, rdy, dreq, wf, sks, skd, pset, dgo, tload} = '0;
		clean = 1'b1;
		res = '0;
		pmode = PM_ACTIVE;
		dcode = DIAG_OK;
		tval = 8'h00;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		t_power_up();
		t_pairs();
		t_cmd();
		t_status();
		t_link();
		t_soft();
		summarize();
	end

endmodule : disk_task_file_tb
